// File: hdl/dplm_ctrl.sv
/*
 * Mode and sequencing controller for three digital loops, each steering
 * a paired analog loop divider. Phase error is given as a signed word
 * per loop; reference validity is given per input. Analog lock is modelled
 * by a settle counter after calibration.
 */
`timescale 1ns/1ps

// Notes on behaviour
// R1: DCO step adds or subtracts freq step value to the divider numerator.
// R2: Stepped numerator drives analog loop and any cascaded downstream loop.
// R3: Software keeps loop bandwidth below all three limits.
// R4: Independent mode: each digital loop picks its own reference input.
// R5: After start-up analog loops lock to crystal and free-run.
// R6: With valid reference each digital loop acquires lock by its own priority.
// R7: Phase error is filtered and adjusts the analog divider numerator.
// R8: Independent loops lock and unlock without touching each other.
// R9: Cascaded mode: all locked outputs follow loop three reference.
// R10: Cascaded mode without reference: all analog loops free-run on crystal.
// R11: Cascaded loops one, two keep lock while loop three free-runs.
// R12: Loop three offset passes to cascaded loops one and two.
// R13: Software confirms loop three lock, toggles enable, rechecks lock.
// R14: Software never routes one oscillator to both references of a pair.
// R15: With loops one, two disabled, oscillators follow loop three domain.
// R16: Analog-only mode ignores digital loops; cascade and DCO still work. Here a DCO step is cleared again after one cycle.
// R17: Analog-only start-up locks analog loops in start-order sequence.
// R18: Non-cascaded loop in analog-only mode locks to crystal in its turn.
// R19: Denominator select zero picks 24-bit, one picks fixed 40-bit.
// R20: Software prefers 24-bit denominator when the digital loop is off.
// R21: Each digital loop has detector, filter and 40-bit sigma-delta divider.
// R22: Every digital and analog loop reports a lock status flag.
module dplm_ctrl
    import dplm_pkg::*;
#(
    parameter int LOCK_CYCLES = LOCK_CYC,
    parameter int ERR_W = 16,
    parameter int GAIN_SH = 4
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RSTN_I,
    // Mode and configuration
    input wire logic [1:0] MODE_I,
    input wire dplm_cfg_t [NUM_LOOPS-1:0] CFG_I,
    input wire dplm_dco_t [NUM_LOOPS-1:0] DCO_I,
    // Reference side
    input wire logic [3:0] REF_VALID_I,
    input wire logic [NUM_LOOPS-1:0][ERR_W-1:0] PHASE_ERR_I,
    // Divider and status outputs
    output logic [NUM_LOOPS-1:0][NUM_W-1:0] NUM_O,
    output logic [NUM_LOOPS-1:0][NUM_W-1:0] DEN_O,
    output logic [NUM_LOOPS-1:0] SDM_BIT_O,
    output logic [NUM_LOOPS-1:0] FROM_LOOP3_O,
    output logic [NUM_LOOPS-1:0] ANALOG_LOCK_O,
    output logic [NUM_LOOPS-1:0] DIGITAL_LOCK_O,
    output logic [NUM_LOOPS-1:0] FREE_RUN_O
);
    // ==========================================================
    // Helpers
    function automatic logic [NUM_W-1:0] sext_err(input logic [ERR_W-1:0] e);
        sext_err = {{(NUM_W-ERR_W){e[ERR_W-1]}}, e};
    endfunction

    function automatic logic in_lock_window(input logic [ERR_W-1:0] e);
        logic [ERR_W-1:0] mag;
        mag = e[ERR_W-1] ? (~e + 1'b1) : e;
        in_lock_window = (mag >> GAIN_SH) == '0;
    endfunction

    // ==========================================================
    // State
    dplm_ast_t ast_r [NUM_LOOPS];
    dplm_ast_t ast_nxt [NUM_LOOPS];
    logic [CNT_W-1:0] cnt_r [NUM_LOOPS];
    logic [CNT_W-1:0] cnt_nxt [NUM_LOOPS];
    logic [NUM_W-1:0] num_r [NUM_LOOPS];
    logic [NUM_W-1:0] num_nxt [NUM_LOOPS];
    logic [NUM_W-1:0] dlf_r [NUM_LOOPS];
    logic [NUM_W-1:0] dlf_nxt [NUM_LOOPS];
    logic [NUM_W:0] acc_r [NUM_LOOPS];
    logic [NUM_W:0] acc_nxt [NUM_LOOPS];
    logic [NUM_LOOPS-1:0] en_d_r;
    logic [NUM_LOOPS-1:0] dlock_r;
    logic [NUM_LOOPS-1:0] dlock_nxt;
    logic [NUM_LOOPS-1:0] step_d_r;
    logic [PRIO_W:0] turn_r;
    logic [PRIO_W:0] turn_nxt;

    logic [NUM_LOOPS-1:0] dpll_active;
    logic [NUM_LOOPS-1:0] ref_ok;
    logic [NUM_LOOPS-1:0] casc;
    logic [NUM_LOOPS-1:0] my_turn;
    logic [NUM_LOOPS-1:0] step_pulse;
    logic all_prior_locked;
    logic signed [NUM_W-1:0] err_step [NUM_LOOPS];

    // ==========================================================
    // Steering terms
    always_comb begin
        all_prior_locked = 1'b1;
        for (int i = 0; i < NUM_LOOPS; i++) begin
            // R16 digital loops unused
            dpll_active[i] = CFG_I[i].dpll_en && (MODE_I != MODE_AONLY);
            // R4 own reference choice
            if (MODE_I == MODE_CASC && i != NUM_LOOPS-1 && CFG_I[i].casc_from3) begin
                // R9 cascaded loops follow loop three domain
                ref_ok[i] = ast_r[NUM_LOOPS-1] == DPLM_LOCK;
            end else begin
                ref_ok[i] = REF_VALID_I[CFG_I[i].ref_sel];
            end
            casc[i] = (i != NUM_LOOPS-1) && CFG_I[i].casc_from3 && (MODE_I != MODE_INDEP);
            // R17 start-order turn
            my_turn[i] = (MODE_I != MODE_AONLY) ||
                ({1'b0, CFG_I[i].analog_loop_start_order} <= turn_r);
            step_pulse[i] = DCO_I[i].dco_step && !step_d_r[i];
            // R7 signed filter step, keeps sign of the error
            err_step[i] = $signed(sext_err(PHASE_ERR_I[i])) >>> GAIN_SH;
        end
        for (int i = 0; i < NUM_LOOPS; i++) begin
            if (CFG_I[i].analog_loop_enable &&
                {1'b0, CFG_I[i].analog_loop_start_order} == turn_r &&
                ast_r[i] != DPLM_LOCK) begin
                all_prior_locked = 1'b0;
            end
        end
    end

    // ==========================================================
    // Per-loop analog sequencing, filter and numerator
    always_comb begin
        turn_nxt = turn_r;
        // R17 turn advances once its loops lock
        if (all_prior_locked && turn_r != {1'b1, {PRIO_W{1'b0}}}) begin
            turn_nxt = turn_r + 1'b1;
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_LOOPS; i++) begin
            ast_nxt[i] = ast_r[i];
            cnt_nxt[i] = cnt_r[i];
            dlf_nxt[i] = dlf_r[i];
            num_nxt[i] = num_r[i];
            dlock_nxt[i] = 1'b0;
            case (ast_r[i])
                DPLM_OFF: begin
                    // R13 rising enable recalibrates oscillator
                    if (CFG_I[i].analog_loop_enable && !en_d_r[i]) begin
                        ast_nxt[i] = DPLM_WAIT;
                        cnt_nxt[i] = '0;
                    end
                end
                DPLM_WAIT: begin
                    // R18 crystal lock in its turn
                    if (my_turn[i] && (!casc[i] || ast_r[NUM_LOOPS-1] == DPLM_LOCK)) begin
                        ast_nxt[i] = DPLM_ACQ;
                    end
                end
                DPLM_ACQ: begin
                    if (cnt_r[i] == CNT_W'(LOCK_CYCLES - 1)) begin
                        // R5 free-run lock on crystal
                        ast_nxt[i] = DPLM_LOCK;
                    end else begin
                        cnt_nxt[i] = cnt_r[i] + 1'b1;
                    end
                end
                DPLM_LOCK: ;
                default: ast_nxt[i] = DPLM_OFF;
            endcase
            if (!CFG_I[i].analog_loop_enable) begin
                ast_nxt[i] = DPLM_OFF;
            end
            // R6 R8 per-loop acquisition, no cross coupling
            if (dpll_active[i] && ref_ok[i] && ast_r[i] == DPLM_LOCK) begin
                // R7 R21 filter phase error into numerator
                dlf_nxt[i] = dlf_r[i] + err_step[i];
                // R11 keep lock while error stays in window
                dlock_nxt[i] = in_lock_window(PHASE_ERR_I[i]);
            end else if (!dpll_active[i]) begin
                dlf_nxt[i] = '0;
            end
            // R10 no reference holds last word, free-run or holdover
            num_nxt[i] = CFG_I[i].base_num + dlf_nxt[i];
            // R1 R16 DCO step; without dpll_active, as in analog-only mode, it lasts one cycle
            if (DCO_I[i].dco_en && step_pulse[i]) begin
                dlf_nxt[i] = DCO_I[i].dco_inc ? dlf_nxt[i] + DCO_I[i].freq_step_value
                                              : dlf_nxt[i] - DCO_I[i].freq_step_value;
                num_nxt[i] = CFG_I[i].base_num + dlf_nxt[i];
            end
        end
    end

    // ==========================================================
    // Sigma-delta first order modulator
    always_comb begin
        for (int i = 0; i < NUM_LOOPS; i++) begin
            acc_nxt[i] = {1'b0, acc_r[i][NUM_W-1:0]} + {1'b0, num_r[i]};
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            for (int i = 0; i < NUM_LOOPS; i++) begin
                acc_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_LOOPS; i++) begin
                acc_r[i] <= acc_nxt[i];
            end
        end
    end

    // ==========================================================
    // Analog sequencing registers
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            for (int i = 0; i < NUM_LOOPS; i++) begin
                ast_r[i] <= DPLM_OFF;
                cnt_r[i] <= '0;
            end
            en_d_r <= '0;
        end else begin
            for (int i = 0; i < NUM_LOOPS; i++) begin
                ast_r[i] <= ast_nxt[i];
                cnt_r[i] <= cnt_nxt[i];
                en_d_r[i] <= CFG_I[i].analog_loop_enable;
            end
        end
    end

    // ==========================================================
    // Filter, numerator and digital lock registers
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            for (int i = 0; i < NUM_LOOPS; i++) begin
                num_r[i] <= NUM_RST;
                dlf_r[i] <= '0;
            end
            dlock_r <= '0;
            step_d_r <= '0;
        end else begin
            for (int i = 0; i < NUM_LOOPS; i++) begin
                num_r[i] <= num_nxt[i];
                dlf_r[i] <= dlf_nxt[i];
                step_d_r[i] <= DCO_I[i].dco_step;
            end
            dlock_r <= dlock_nxt;
        end
    end

    // ==========================================================
    // Start-order turn register
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            turn_r <= '0;
        end else begin
            turn_r <= turn_nxt;
        end
    end

    // ==========================================================
    // Outputs
    always_comb begin
        for (int i = 0; i < NUM_LOOPS; i++) begin
            NUM_O[i] = num_r[i];
            // R19 denominator choice
            DEN_O[i] = CFG_I[i].denominator_select ? DEN40_FIXED
                                                   : {{(NUM_W-DEN24_W){1'b0}}, CFG_I[i].den24};
            SDM_BIT_O[i] = acc_r[i][NUM_W];
            // R2 R12 R15 cascaded reference from loop three
            FROM_LOOP3_O[i] = casc[i];
            // R22 lock flags
            ANALOG_LOCK_O[i] = ast_r[i] == DPLM_LOCK;
            DIGITAL_LOCK_O[i] = dlock_r[i];
            FREE_RUN_O[i] = (ast_r[i] == DPLM_LOCK) && !dlock_r[i];
        end
    end
endmodule

// File: hdl/dplm_pkg.sv
/*
 * Package for the loop mode controller: widths, encodings and reset values.
 * Assumes a single 125 MHz clock domain and plain control ports.
 */
package dplm_pkg;
    // ==========================================================
    // Widths and counts
    localparam int NUM_LOOPS = 3;
    localparam int NUM_W = 40;
    localparam int DEN24_W = 24;
    localparam int WORD_W = 32;
    localparam int REF_W = 2;
    localparam int PRIO_W = 2;
    // Cycles a loop needs to settle before it reports lock
    localparam int LOCK_CYC = 64;
    localparam int CNT_W = 7;
    localparam logic [NUM_W-1:0] NUM_RST = 40'h00_0000_0000;
    localparam logic [NUM_W-1:0] DEN40_FIXED = 40'hFF_FFFF_FFFF;
    localparam logic [DEN24_W-1:0] DEN24_RST = 24'hFFFFFF;
    localparam logic [1:0] MODE_INDEP = 2'h0;
    localparam logic [1:0] MODE_CASC = 2'h1;
    localparam logic [1:0] MODE_AONLY = 2'h2;

    // ==========================================================
    // Per-loop analog state
    typedef enum logic [3:0] {
        DPLM_OFF = 4'h1,
        DPLM_WAIT = 4'h2,
        DPLM_ACQ = 4'h4,
        DPLM_LOCK = 4'h8
    } dplm_ast_t;

    typedef struct packed {
        logic dco_en;
        logic dco_inc;
        logic dco_step;
        logic [NUM_W-1:0] freq_step_value;
    } dplm_dco_t;

    typedef struct packed {
        logic dpll_en;
        logic analog_loop_enable;
        logic casc_from3;
        logic denominator_select;
        logic [REF_W-1:0] ref_sel;
        logic [PRIO_W-1:0] analog_loop_start_order;
        logic [NUM_W-1:0] base_num;
        logic [DEN24_W-1:0] den24;
    } dplm_cfg_t;
endpackage

// File: test/dplm_ctrl_properties.sv
/* Port checker for dplm_ctrl.
   Assumes a settle count of at least 4 cycles. */
`timescale 1ns/1ps
module dplm_ctrl_properties
    import dplm_pkg::*;
(
    // Inputs watched
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic [1:0] MODE_I,
    input wire dplm_cfg_t [NUM_LOOPS-1:0] CFG_I,
    // Outputs watched
    input wire logic [NUM_LOOPS-1:0][NUM_W-1:0] DEN_O,
    input wire logic [NUM_LOOPS-1:0] FROM_LOOP3_O,
    input wire logic [NUM_LOOPS-1:0] ANALOG_LOCK_O,
    input wire logic [NUM_LOOPS-1:0] DIGITAL_LOCK_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    property p_den_fix;
        CFG_I[0].denominator_select |-> DEN_O[0] == DEN40_FIXED;
    endproperty
    a_den_fix: assert property (p_den_fix) else $error("den fixed");
    property p_den_prg;
        !CFG_I[1].denominator_select |-> DEN_O[1] == {16'h0000, CFG_I[1].den24};
    endproperty
    a_den_prg: assert property (p_den_prg) else $error("den prog");
    property p_from3;
        FROM_LOOP3_O[0] == (MODE_I != MODE_INDEP && CFG_I[0].casc_from3);
    endproperty
    a_from3: assert property (p_from3) else $error("from3");
    property p_dig;
        DIGITAL_LOCK_O[2] |-> $past(ANALOG_LOCK_O[2]);
    endproperty
    a_dig: assert property (p_dig) else $error("dlock w/o alock");
    property p_aonly;
        $past(MODE_I) == MODE_AONLY |-> DIGITAL_LOCK_O == 3'h0;
    endproperty
    a_aonly: assert property (p_aonly) else $error("dlock aonly");
    property p_settle;
        $rose(ANALOG_LOCK_O[2]) |-> $past(CFG_I[2].analog_loop_enable, 4);
    endproperty
    a_settle: assert property (p_settle) else $error("early lock");
    property p_casc;
        $rose(ANALOG_LOCK_O[0]) && FROM_LOOP3_O[0] |-> ANALOG_LOCK_O[2];
    endproperty
    a_casc: assert property (p_casc) else $error("casc order");
    property p_indep;
        MODE_I == MODE_INDEP && $fell(ANALOG_LOCK_O[1]) && $past(ANALOG_LOCK_O[0])
            && $past(CFG_I[0].analog_loop_enable) |-> ANALOG_LOCK_O[0];
    endproperty
    a_indep: assert property (p_indep) else $error("loop disturbed");
endmodule
bind dplm_ctrl dplm_ctrl_properties u_props (.CLK_I(CLK_I), .RSTN_I(RSTN_I),
    .MODE_I(MODE_I), .CFG_I(CFG_I), .DEN_O(DEN_O), .FROM_LOOP3_O(FROM_LOOP3_O),
    .ANALOG_LOCK_O(ANALOG_LOCK_O), .DIGITAL_LOCK_O(DIGITAL_LOCK_O));

// File: test/dplm_ctrl_tb.sv
/* Bench for dplm_ctrl with a settle count of 4.
   Reference side from dplm_ref_model; checker bound separately. */
`timescale 1ns/1ps
module dplm_ctrl_tb
    import dplm_pkg::*;
;
    // ==========================================================
    // Signals
    logic CLK_I = 1'b0;
    logic RSTN_I = 1'b0;
    logic [1:0] mode = MODE_AONLY;
    dplm_cfg_t [2:0] cfg = '0;
    dplm_dco_t [2:0] dco = '0;
    logic [3:0] vreq = 4'h0;
    logic [15:0] err = 16'h0000;
    logic [3:0] rv;
    logic [2:0][15:0] perr;
    logic [2:0][39:0] num, den;
    logic [2:0] sdm, from3, alock, dlock, frun;
    int bad_count = 0;
    int samples_checked = 0;
    localparam logic [39:0] BASE = 40'h01_0000_0000;
    localparam logic [39:0] STEP = 40'h00_0000_1000;
    dplm_ref_model ref_m (.clk_i(CLK_I), .valid_req_i(vreq), .err_req_i(err),
        .ref_valid_o(rv), .phase_err_o(perr));
    dplm_ctrl #(.LOCK_CYCLES(4)) dut (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .MODE_I(mode),
        .CFG_I(cfg), .DCO_I(dco), .REF_VALID_I(rv), .PHASE_ERR_I(perr), .NUM_O(num),
        .DEN_O(den), .SDM_BIT_O(sdm), .FROM_LOOP3_O(from3), .ANALOG_LOCK_O(alock),
        .DIGITAL_LOCK_O(dlock), .FREE_RUN_O(frun));
    initial begin
        forever #4 CLK_I = ~CLK_I;
    end
    // ==========================================================
    // Helpers
    task automatic tick(input int n);
        repeat (n) @(posedge CLK_I);
        #1;
    endtask
    task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic wait_hi(input bit dig, input int i);
        int n;
        n = 0;
        while ((dig ? dlock[i] : alock[i]) !== 1'b1 && n < 300) begin
            tick(1);
            n++;
        end
        if ((dig ? dlock[i] : alock[i]) !== 1'b1) begin
            chk("lock wait", 40'h1, 40'h0);
            conclude();
        end
    endtask
    task automatic pulse();
        dco[0].dco_step = 1'b1;
        tick(1);
        dco[0].dco_step = 1'b0;
        tick(3);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_start();
        for (int i = 0; i < 3; i++) begin
            cfg[i].analog_loop_enable = 1'b1;
            cfg[i].dpll_en = 1'b1;
            cfg[i].den24 = 24'h0ABCDE;
            cfg[i].base_num = BASE;
        end
        cfg[0].analog_loop_start_order = 2'h1;
        cfg[2].analog_loop_start_order = 2'h2;
        tick(16);
        RSTN_I = 1'b1;
        wait_hi(0, 1);
        chk("alock0", 40'h0, 40'(alock[0]));
        wait_hi(0, 0);
        chk("alock2", 40'h0, 40'(alock[2]));
        wait_hi(0, 2);
        chk("dlock", 40'h0, 40'(dlock));
        cfg[0].denominator_select = 1'b1;
        tick(1);
        chk("den fix", DEN40_FIXED, den[0]);
        chk("den prg", 40'h00_000A_BCDE, den[1]);
        chk("frun aonly", 40'h7, 40'(frun));
        $display("start order and denominator done");
    endtask
    task automatic t_indep();
        int n;
        mode = MODE_INDEP;
        vreq = 4'hF;
        for (int i = 0; i < 3; i++) wait_hi(1, i);
        chk("frun indep", 40'h0, 40'(frun));
        chk("num", BASE, num[0]);
        dco[0] = {1'b1, 1'b1, 1'b0, STEP};
        pulse();
        chk("num up", BASE + STEP, num[0]);
        dco[0].dco_inc = 1'b0;
        pulse();
        chk("num down", BASE, num[0]);
        n = 0;
        for (int k = 0; k < 512; k++) begin
            n += sdm[0];
            tick(1);
        end
        chk("sdm carries", 40'h2, 40'(n));
        cfg[1].analog_loop_enable = 1'b0;
        tick(4);
        chk("alock", 40'h5, 40'(alock));
        chk("dlock", 40'h5, 40'(dlock));
        err = 16'h0100;
        tick(4);
        chk("dlock big err", 40'h0, 40'(dlock));
        chk("num err up", BASE + 40'h40, num[0]);
        err = 16'hFF00;
        tick(4);
        chk("num err down", BASE, num[0]);
        err = 16'h0000;
        tick(2);
        chk("dlock back", 40'h5, 40'(dlock));
        $display("independent and step done");
    endtask
    task automatic t_casc();
        mode = MODE_CASC;
        cfg[0].casc_from3 = 1'b1; // loop 0 analog side waits for loop three analog lock before it acquires
        cfg[0].dpll_en = 1'b0;
        cfg[0].denominator_select = 1'b0;
        cfg[0].analog_loop_enable = 1'b0;
        cfg[2].analog_loop_enable = 1'b0;
        tick(2);
        chk("from3", 40'h1, 40'(from3[0]));
        cfg[0].analog_loop_enable = 1'b1;
        tick(20);
        chk("alock0 casc", 40'h0, 40'(alock[0]));
        cfg[2].analog_loop_enable = 1'b1;
        wait_hi(0, 2);
        wait_hi(0, 0);
        cfg[0].analog_loop_enable = 1'b0;
        tick(1);
        cfg[0].analog_loop_enable = 1'b1;
        tick(1);
        chk("alock0 cal", 40'h0, 40'(alock[0]));
        wait_hi(0, 0);
        $display("cascade done");
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        t_start();
        t_indep();
        t_casc();
        conclude();
    end
endmodule

// File: test/dplm_ref_model.sv
/* Reference-side stand-in: input validity and per-loop phase error.
   Assumes the bench sets requests just after a rising edge. */
`timescale 1ns/1ps
module dplm_ref_model (
    // Bench requests
    input wire logic clk_i,
    input wire logic [3:0] valid_req_i,
    input wire logic [15:0] err_req_i,
    // Toward controller
    output logic [3:0] ref_valid_o,
    output logic [2:0][15:0] phase_err_o
);
    logic [15:0] junk_r = 16'h5A5A;
    always_ff @(posedge clk_i) junk_r <= ~junk_r + 16'h0001;
    assign ref_valid_o = valid_req_i;
    // error only meaningful with a valid input
    assign phase_err_o = (|valid_req_i) ? {3{err_req_i}} : {3{junk_r}};
endmodule
